// *** core/dac_pkg.sv ***
// Package for the DMA channel address control block.
// Assumes a single 20 MHz clock and an AXI4-Lite register bus.
package dac_pkg;
    localparam logic [7:0] DAC_OFF_CTRL = 8'h00;
    localparam logic [7:0] DAC_OFF_SRC = 8'h04;
    localparam logic [7:0] DAC_OFF_DST = 8'h08;
    localparam logic [7:0] DAC_OFF_CNT = 8'h0C;
    localparam logic [7:0] DAC_OFF_CUR_SRC = 8'h10;
    localparam logic [7:0] DAC_OFF_CUR_DST = 8'h14;
    localparam logic [7:0] DAC_OFF_CUR_CNT = 8'h18;
    localparam logic [7:0] DAC_OFF_IRQ_STAT = 8'h1C;
    localparam logic [7:0] DAC_OFF_IRQ_MASK = 8'h20;
    localparam int DAC_EN_BIT = 0;
    localparam int DAC_SRC_SEL_LO = 4;
    localparam int DAC_DST_SEL_LO = 6;
    localparam int DAC_WIS_LO = 12;
    localparam int DAC_WIS_HALF = 2;
    localparam int DAC_WIS_WRAP = 0;
    localparam logic [1:0] DAC_SEL_INC = 2'h0;
    localparam logic [1:0] DAC_SEL_FIX = 2'h2;
    localparam logic [1:0] DAC_SEL_WRAP = 2'h3;
    localparam int DAC_IRQ_HALF = 0;
    localparam int DAC_IRQ_WRAP = 1;
    localparam int DAC_IRQ_DONE = 2;
    localparam logic [1:0] DAC_RESP_OKAY = 2'h0;
    localparam logic [1:0] DAC_RESP_SLVERR = 2'h2;
    localparam logic [31:0] DAC_ZERO32 = 32'h0000_0000;
    typedef enum logic [1:0] {DAC_IDLE, DAC_READ, DAC_WRITE} dac_state_t;
endpackage

// *** core/dac_addr_step.sv ***
// One address stepper: increment, hold or wrap-reload of a current address.
// Assumes the caller loads nxt into the current address once per finished transfer.
`timescale 1ns/1ps
`default_nettype none
module dac_addr_step
    import dac_pkg::*;
#(
    parameter int AW = 32
) (
    input wire logic [1:0] sel,
    input wire logic [AW-1:0] cur,
    input wire logic [AW-1:0] prog,
    input wire logic [AW-1:0] width,
    input wire logic reload,
    output logic [AW-1:0] nxt
);
    // Wrap mode reloads from the programmed address at zero count, fixed holds
    wire logic is_wrap = (sel == DAC_SEL_WRAP);
    wire logic is_fix = (sel == DAC_SEL_FIX);
    assign nxt = (is_wrap && reload) ? prog : (is_fix ? cur : cur + width);
endmodule
`default_nettype wire

// *** core/dac_channel.sv ***
// DMA channel address control: address stepping, byte count, wraparound, irq.
// Assumes a transfer engine outside moves the data; xfer_done marks each beat.
// Contract
// R1 - Destination address stepped per selector bits 7:6
// R2 - Software uses fixed destination for single FIFO
// R3 - Source address stepped per selector bits 5:4
// R4 - Wrap: reload address and count at zero
// R5 - Wrapping repeats until software clears enable
// R6 - Disable finishes beat, drops staging buffer; code drops xfer_req and flushes one cycle after enable clears
// R7 - Selector x1x1 raises half and wrap interrupts
// R8 - Count decrements by width per transfer
`timescale 1ns/1ps
`default_nettype none
module dac_channel
    import dac_pkg::*;
#(
    parameter int AW = 32
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic xfer_done,
    input wire logic [2:0] xfer_width,
    output logic xfer_req,
    output logic [AW-1:0] xfer_src,
    output logic [AW-1:0] xfer_dst,
    output logic buf_flush,
    output logic irq
);
    // Elaboration check: the current registers and the read mux serve 8 to 32 bits
    if (AW < 8 || AW > 32) begin : g_aw_check
        $error("AW must be 8..32");
    end

    logic [31:0] ctrl_q;
    logic [AW-1:0] psrc_q, pdst_q, pcnt_q, csrc_q, cdst_q, ccnt_q, half_q;
    logic [2:0] stat_q, mask_q;
    logic aw_got_q, w_got_q;
    logic [7:0] awa_q;
    logic [31:0] wd_q;
    logic [3:0] ws_q;
    logic en_q;

    // Write channel capture, either order
    wire logic aw_hs = s_axi_awvalid && s_axi_awready;
    wire logic w_hs = s_axi_wvalid && s_axi_wready;
    wire logic [7:0] wa = aw_hs ? s_axi_awaddr : awa_q;
    wire logic [31:0] wd = w_hs ? s_axi_wdata : wd_q;
    wire logic [3:0] ws = w_hs ? s_axi_wstrb : ws_q;
    wire logic wr_go = (aw_got_q || aw_hs) && (w_got_q || w_hs) && !s_axi_bvalid;
    wire logic [31:0] bmask = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
    function automatic logic [31:0] merge(input logic [31:0] old);
        merge = (old & ~bmask) | (wd & bmask);
    endfunction
    wire logic wr_ctrl = wr_go && wa == DAC_OFF_CTRL;
    wire logic wr_src = wr_go && wa == DAC_OFF_SRC;
    wire logic wr_dst = wr_go && wa == DAC_OFF_DST;
    wire logic wr_cnt = wr_go && wa == DAC_OFF_CNT;
    wire logic wr_stat = wr_go && wa == DAC_OFF_IRQ_STAT;
    wire logic wr_mask = wr_go && wa == DAC_OFF_IRQ_MASK;
    wire logic wr_ok = wr_ctrl | wr_src | wr_dst | wr_cnt | wr_stat | wr_mask;

    // Control fields
    wire logic en = ctrl_q[DAC_EN_BIT];
    wire logic [1:0] ssel = ctrl_q[DAC_SRC_SEL_LO +: 2];
    wire logic [1:0] dsel = ctrl_q[DAC_DST_SEL_LO +: 2];
    wire logic [3:0] wis = ctrl_q[DAC_WIS_LO +: 4];
    wire logic wrap_mode = (ssel == DAC_SEL_WRAP) || (dsel == DAC_SEL_WRAP);
    wire logic [31:0] ctrl_new = (ctrl_q & ~bmask) | (wd & bmask); // Inline so it follows wd and bmask
    wire logic start = wr_ctrl && ctrl_new[DAC_EN_BIT] && !en;

    // Count and stepping
    wire logic [AW-1:0] wdt = AW'(xfer_width);
    wire logic beat = xfer_done && xfer_req;
    wire logic [AW-1:0] cnt_dec = (ccnt_q > wdt) ? ccnt_q - wdt : '0; // [R8]
    wire logic at_zero = beat && cnt_dec == '0;
    wire logic reload = at_zero && wrap_mode && en; // [R4] [R5]
    wire logic cross_half = beat && ccnt_q > half_q && cnt_dec <= half_q;
    logic [AW-1:0] src_nxt, dst_nxt;

    dac_addr_step #(.AW(AW)) u_src (
        .sel(ssel), .cur(csrc_q), .prog(psrc_q), .width(wdt), .reload(reload), .nxt(src_nxt)); // [R3]
    dac_addr_step #(.AW(AW)) u_dst (
        .sel(dsel), .cur(cdst_q), .prog(pdst_q), .width(wdt), .reload(reload), .nxt(dst_nxt)); // [R1]

    // Interrupt events, only in wraparound operation for half and wrap
    wire logic ev_half = cross_half && wrap_mode && wis[DAC_WIS_HALF]; // [R7]
    wire logic ev_wrap = reload && wis[DAC_WIS_WRAP]; // [R7]
    wire logic ev_done = at_zero && !wrap_mode;
    wire logic [2:0] ev = {ev_done, ev_wrap, ev_half};
    wire logic [2:0] stat_d = ev | (stat_q & ~(wr_stat ? wd[2:0] & ws[0] * 3'h7 : 3'h0));

    // Read mux
    logic [31:0] rmux;
    wire logic rd_ok = s_axi_araddr <= DAC_OFF_IRQ_MASK && s_axi_araddr[1:0] == 2'h0;
    always_comb begin
        rmux = DAC_ZERO32;
        unique case (s_axi_araddr)
            DAC_OFF_CTRL: rmux = ctrl_q;
            DAC_OFF_SRC: rmux = 32'(psrc_q);
            DAC_OFF_DST: rmux = 32'(pdst_q);
            DAC_OFF_CNT: rmux = 32'(pcnt_q);
            DAC_OFF_CUR_SRC: rmux = 32'(csrc_q);
            DAC_OFF_CUR_DST: rmux = 32'(cdst_q);
            DAC_OFF_CUR_CNT: rmux = 32'(ccnt_q);
            DAC_OFF_IRQ_STAT: rmux = 32'(stat_q);
            DAC_OFF_IRQ_MASK: rmux = 32'(mask_q);
            default: rmux = DAC_ZERO32;
        endcase
    end

    // Bus handshake state
    always_ff @(posedge clk) begin
        if (srst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= DAC_RESP_OKAY;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awa_q <= 8'h00;
            wd_q <= DAC_ZERO32;
            ws_q <= 4'h0;
        end else begin
            s_axi_awready <= !aw_got_q && !aw_hs && !s_axi_bvalid && !wr_go;
            s_axi_wready <= !w_got_q && !w_hs && !s_axi_bvalid && !wr_go;
            aw_got_q <= (aw_got_q || aw_hs) && !wr_go;
            w_got_q <= (w_got_q || w_hs) && !wr_go;
            if (aw_hs) awa_q <= s_axi_awaddr;
            if (w_hs) begin
                wd_q <= s_axi_wdata;
                ws_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? DAC_RESP_OKAY : DAC_RESP_SLVERR;
            end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
        end
    end

    // Read channel
    always_ff @(posedge clk) begin
        if (srst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= DAC_ZERO32;
            s_axi_rresp <= DAC_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_ok ? rmux : DAC_ZERO32;
                s_axi_rresp <= rd_ok ? DAC_RESP_OKAY : DAC_RESP_SLVERR;
            end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
        end
    end

    // Registers and channel engine
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_q <= DAC_ZERO32;
            psrc_q <= '0;
            pdst_q <= '0;
            pcnt_q <= '0;
            csrc_q <= '0;
            cdst_q <= '0;
            ccnt_q <= '0;
            half_q <= '0;
            stat_q <= 3'h0;
            mask_q <= 3'h0;
            xfer_req <= 1'b0;
            buf_flush <= 1'b0;
            en_q <= 1'b0;
            irq <= 1'b0;
        end else begin
            if (wr_ctrl) ctrl_q <= ctrl_new;
            if (wr_src) psrc_q <= AW'(merge(32'(psrc_q)));
            if (wr_dst) pdst_q <= AW'(merge(32'(pdst_q)));
            if (wr_cnt) pcnt_q <= AW'(merge(32'(pcnt_q)));
            if (wr_mask) mask_q <= (mask_q & ~bmask[2:0]) | (wd[2:0] & bmask[2:0]);
            stat_q <= stat_d; // Event set wins over write-one clear
            en_q <= en;
            // Disable drops staged data one cycle after enable clears, without waiting for the active beat
            buf_flush <= en_q && !en; // [R6]
            if (start) begin
                csrc_q <= psrc_q;
                cdst_q <= pdst_q;
                ccnt_q <= pcnt_q;
                half_q <= pcnt_q >> 1;
                xfer_req <= pcnt_q != '0;
            end else if (beat) begin
                csrc_q <= src_nxt;
                cdst_q <= dst_nxt;
                ccnt_q <= reload ? pcnt_q : cnt_dec; // [R4]
                // A done in the first cycle with enable low still steps; no new beat once disabled
                xfer_req <= reload ? (pcnt_q != '0) : (!at_zero && en); // [R5] [R6]
            end else if (!en) xfer_req <= 1'b0;
            irq <= |(stat_d & mask_q);
        end
    end

    assign xfer_src = csrc_q;
    assign xfer_dst = cdst_q;
endmodule
`default_nettype wire

// *** bench/dac_channel_asserts.sv ***
// Checker for dac_channel: bus handshakes, flush pulse, reset state.
// Sees only the top ports; attached by the bind below.
`timescale 1ns/1ps
`default_nettype none
module dac_channel_chk
    import dac_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic s_axi_awready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] s_axi_rresp,
    input wire logic [31:0] s_axi_rdata,
    input wire logic xfer_req,
    input wire logic buf_flush,
    input wire logic irq
);
    // All checks on clk, quiet while reset is high
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    b_resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped before bready");
    r_resp_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer changed before rready");
    aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("awready high with response pending");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("arready high with read pending");
    r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    b_resp_legal_a: assert property (s_axi_bvalid |-> s_axi_bresp == DAC_RESP_OKAY || s_axi_bresp == DAC_RESP_SLVERR)
        else $error("bad write response code");
    err_data_zero_a: assert property (s_axi_rvalid && s_axi_rresp == DAC_RESP_SLVERR |-> s_axi_rdata == DAC_ZERO32)
        else $error("error read returned data");
    flush_pulse_a: assert property (buf_flush |=> !buf_flush)
        else $error("flush longer than one cycle");
    rst_clear_a: assert property ($past(srst) |-> !xfer_req && !irq && !buf_flush && !s_axi_bvalid && !s_axi_awready)
        else $error("outputs not clear after reset");
endmodule
bind dac_channel dac_channel_chk chk_i (.clk(clk), .srst(srst), .s_axi_awready(s_axi_awready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rresp(s_axi_rresp), .s_axi_rdata(s_axi_rdata),
    .xfer_req(xfer_req), .buf_flush(buf_flush), .irq(irq));
`default_nettype wire

// *** bench/dac_xfer_partner.sv ***
// Transfer engine on the far side: finishes each requested beat.
// Assumes the bench sets lat; a done pulse is followed by one idle cycle.
`timescale 1ns/1ps
`default_nettype none
module dac_xfer_partner (
    input wire logic clk,
    input wire logic srst,
    input wire logic xfer_req,
    input wire logic [2:0] lat,
    output logic xfer_done
);
    logic [2:0] cnt_q;
    logic busy_q;
    // Waits lat+1 cycles per beat, then pulses done once
    always_ff @(posedge clk) begin
        xfer_done <= 1'b0;
        if (srst) begin
            busy_q <= 1'b0;
        end else if (busy_q) begin
            busy_q <= cnt_q != 3'h0;
            xfer_done <= cnt_q == 3'h0;
            cnt_q <= cnt_q - 3'h1;
        end else if (xfer_req && !xfer_done) begin
            busy_q <= 1'b1;
            cnt_q <= lat;
        end
    end
endmodule
`default_nettype wire

// *** bench/dac_channel_tb.sv ***
// Testbench for dac_channel: register tasks, partner engine, queued checks.
// Assumes the checker and partner model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; $display("Error %s exp %h got %h", nm, e, g); end end
module dac_channel_tb
    import dac_pkg::*;
;
    logic clk = 0, srst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, done;
    logic awr, wr_rdy, bv, arr, rv, req, flush, irq;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0000_0000, rd, src, dst;
    logic [1:0] br, rr;
    logic [2:0] w = 3'h4, lat = 3'h0;
    logic [3:0] sel;
    logic [33:0] e;
    logic [33:0] exp_q[$];
    int n_mismatch = 0, tests_run = 0, flushes = 0, seed = 32'h8da8_762d, n, k, wb, c;
    dac_channel DUT (.clk(clk), .srst(srst), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(br),
        .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .xfer_done(done),
        .xfer_width(w), .xfer_req(req), .xfer_src(src), .xfer_dst(dst), .buf_flush(flush), .irq(irq));
    dac_xfer_partner eng (.clk(clk), .srst(srst), .xfer_req(req), .lat(lat), .xfer_done(done));
    initial forever #25 clk = ~clk;
    // Takes the oldest note off the queue at each read answer
    always @(posedge clk) begin
        if (bv && bry) `CHK("bresp", DAC_RESP_OKAY, br)
        if (rv && rry) begin
            e = exp_q.pop_front();
            `CHK("read", e, {rr, rd})
        end
        if (flush) flushes++;
    end
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic step();
        @(posedge clk);
        n++;
        if (n > 400) begin
            n_mismatch++;
            wrap_up();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit ta, tw;
        ta = 0; tw = 0; n = 0;
        awa <= a; wd <= d; awv <= 1; wv <= 1;
        while (!(ta && tw)) begin
            step();
            if (awr && !ta) begin ta = 1; awv <= 0; end
            if (wr_rdy && !tw) begin tw = 1; wv <= 0; end
        end
        while (!bv) step();
        bry <= 1; @(posedge clk); bry <= 0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [33:0] x);
        exp_q.push_back(x);
        n = 0; ara <= a; arv <= 1;
        do step(); while (!arr);
        arv <= 0;
        while (!rv) step();
        rry <= 1; @(posedge clk); rry <= 0;
    endtask
    task automatic wait_req(input logic lv);
        n = 0;
        while (req !== lv) step();
    endtask
    // Main sequence: plain runs per selector code, then wraparound
    initial begin
        repeat (8) @(posedge clk);
        srst <= 0;
        @(posedge clk);
        for (k = 0; k < 3; k++) begin
            sel = k == 0 ? 4'h8 : k == 1 ? 4'h2 : 4'h5;
            wb = 1 << ($unsigned($random(seed)) % 3);
            c = wb * (2 + $unsigned($random(seed)) % 3);
            w <= wb[2:0]; lat <= 3'($random(seed));
            wr(DAC_OFF_SRC, 32'h0000_1000); wr(DAC_OFF_DST, 32'h0000_2000); wr(DAC_OFF_CNT, c);
            wr(DAC_OFF_CTRL, {24'h0, sel, 4'h1});
            wait_req(1); wait_req(0);
            `CHK("src", (sel[1:0] == 2'h2 ? 32'h1000 : 32'h1000 + c), src)
            `CHK("dst", (sel[3:2] == 2'h2 ? 32'h2000 : 32'h2000 + c), dst)
            rdchk(DAC_OFF_CUR_SRC, {2'h0, sel[1:0] == 2'h2 ? 32'h1000 : 32'h1000 + c});
            rdchk(DAC_OFF_CUR_DST, {2'h0, sel[3:2] == 2'h2 ? 32'h2000 : 32'h2000 + c});
            rdchk(DAC_OFF_CUR_CNT, {2'h0, 32'h0});
            wr(DAC_OFF_CTRL, 32'h0);
        end
        wr(DAC_OFF_IRQ_STAT, 32'h7); wr(DAC_OFF_IRQ_MASK, 32'h0);
        w <= 3'h4; lat <= 3'h2;
        wr(DAC_OFF_CNT, 32'h10);
        wr(DAC_OFF_CTRL, 32'h0000_50b1);
        repeat (80) @(posedge clk);
        `CHK("req", 1'b1, req)
        `CHK("irq", 1'b0, irq)
        `CHK("dst", 32'h0000_2000, dst)
        rdchk(DAC_OFF_IRQ_STAT, {2'h0, 32'h3});
        rdchk(DAC_OFF_CUR_DST, {2'h0, 32'h2000});
        wr(DAC_OFF_IRQ_MASK, 32'h3);
        @(posedge clk);
        `CHK("irq", 1'b1, irq)
        flushes = 0;
        wr(DAC_OFF_CTRL, 32'h0000_50b0);
        wait_req(0);
        repeat (4) @(posedge clk);
        `CHK("flush", 1, flushes)
        wr(DAC_OFF_IRQ_STAT, 32'h3);
        rdchk(DAC_OFF_IRQ_STAT, {2'h0, 32'h0});
        `CHK("irq", 1'b0, irq)
        rdchk(8'h40, {DAC_RESP_SLVERR, 32'h0});
        wrap_up();
    end
endmodule
`default_nettype wire
